/* File: gp0_board.sv */
// Board model behind the eight port pins
`timescale 1ns/100ps
module gp0_board
	import gp0_pkg::*;
(
	input wire logic aclk,
	input wire gp0_pins_out_type pins,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_lvl,
	output logic [7:0] pin_in
);
	logic [7:0] float_q = 8'h55;
	// Open pins wander so a stale level never passes
	always @(posedge aclk) float_q <= ~float_q;
	// Port drive wins, then board, then pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pins.pin_oe_n[i]) pin_in[i] = pins.pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_lvl[i];
			else if (pins.pull_up_en[i]) pin_in[i] = 1'h1;
			else pin_in[i] = float_q[i];
		end
	end
endmodule

/* File: gp0_checker.sv */
// Bound assertions for the eight-pin port
`timescale 1ns/100ps
module gp0_checker
	import gp0_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [7:0] pin_in,
	input wire gp0_pins_out_type pins,
	input wire logic [7:0] ext_irq_in
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Read address handshake
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_rd_latency: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_live: assert property (s_rd_take ##0 s_axi_araddr == 5'h00 |=> s_axi_rdata == {24'h0, $past(pin_in)})
		else $error("data read not pin level");
	a_rd_stable: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	a_irq_follow: assert property ($past(aresetn) |-> ext_irq_in == $past(pin_in))
		else $error("interrupt feed wrong");
	// Second cycle shows the cleared direction register itself reaching the pins
	a_pins_reset: assert property ($rose(aresetn) |->
		(pins.pin_oe_n == 8'hff && pins.pin_out == 8'h00) ##1 (pins.pin_oe_n == 8'hff))
		else $error("pins not inputs after reset");
	a_pull_low: assert property ((pins.pull_up_en & ~pins.pin_oe_n & ~pins.pin_out) == 8'h00)
		else $error("pull-up on low drive");
endmodule

bind gp0_port gp0_checker u_chk (.*);

/* File: gp0_params.svh */
// Constants for the eight-pin general-purpose port: offsets, widths, reset values
`ifndef GP0_PARAMS_SVH
`define GP0_PARAMS_SVH

`define GP0_PINS 8
`define GP0_ADDR_W 5
`define GP0_DATA_W 32

`define GP0_OFS_DATA 5'h00
`define GP0_OFS_DIR 5'h04
`define GP0_OFS_PULL 5'h08
`define GP0_OFS_RMW 5'h0c

`define GP0_IDX_DATA 2'h0
`define GP0_IDX_DIR 2'h1
`define GP0_IDX_PULL 2'h2
`define GP0_IDX_RMW 2'h3

`define GP0_RST_LATCH 8'h00
`define GP0_RST_DIR 8'h00
`define GP0_RST_PULL 8'h00

`define GP0_RESP_OKAY 2'h0
`define GP0_RESP_SLVERR 2'h2

`endif

/* File: gp0_pin_cell.sv */
// Output stage of one port pin: drive level, enable and pull-up
`timescale 1ns/100ps

module gp0_pin_cell
	import gp0_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic latch_bit,
	input wire logic dir_bit,
	input wire logic pull_bit,
	output logic pin_out,
	output logic pin_oe_n,
	output logic pull_up_en
);

	gp0_pin_state_type s_q;
	gp0_pin_state_type s_d;

	// Next pin state from the three register bits
	always_comb begin
		s_d = s_q;
		s_d.drive = latch_bit;
		s_d.oe_n = ~dir_bit;
		// Pull-up drops out while the pin itself drives low
		s_d.pu = pull_bit & ~(dir_bit & ~latch_bit);
	end

	// Pins start as inputs with no pull-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '{drive: 1'b0, oe_n: 1'b1, pu: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out = s_q.drive;
	assign pin_oe_n = s_q.oe_n;
	assign pull_up_en = s_q.pu;

endmodule

/* File: gp0_pkg.sv */
// Types shared by the port and its pin cells
`include "gp0_params.svh"

package gp0_pkg;

	typedef enum logic [1:0] {
		GP0_WR_IDLE = 2'b01,
		GP0_WR_RESP = 2'b10
	} gp0_wr_state_type;

	typedef struct packed {
		logic [`GP0_PINS-1:0] pin_out;
		logic [`GP0_PINS-1:0] pin_oe_n;
		logic [`GP0_PINS-1:0] pull_up_en;
	} gp0_pins_out_type;

	typedef struct packed {
		logic drive;
		logic oe_n;
		logic pu;
	} gp0_pin_state_type;

	typedef struct packed {
		logic aw_have;
		logic [`GP0_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [`GP0_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		gp0_wr_state_type wr_st;
		logic [1:0] bresp;
		logic rvalid;
		logic [`GP0_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic [`GP0_PINS-1:0] latch;
		logic [`GP0_PINS-1:0] dir;
		logic [`GP0_PINS-1:0] pull;
		logic [`GP0_PINS-1:0] irq;
	} gp0_state_type;

endpackage

/* File: gp0_port.sv */
// Eight-pin general-purpose port with AXI4-Lite register access
`timescale 1ns/100ps
`include "gp0_params.svh"

// Contract
// - Ordinary data register read returns the live pin levels, bit per pin.
// - Read-modify-write read of data register returns the output latch instead.
// - Data register write loads latch; output pins drive the latch bits.
// - Direction bit 0 makes the pin an input, 1 an output.
// - Pull-up select bit 1 connects the pull-up except while the pin drives low, 0 leaves it off.
// - Each pin n also feeds external interrupt input n.
// - Direction and pull-up registers read back the last written value.
// - Bit n of every port register belongs to pin n, bits 0 to 7.
module gp0_port
	import gp0_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`GP0_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`GP0_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`GP0_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`GP0_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`GP0_PINS-1:0] pin_in,
	output gp0_pins_out_type pins,
	output logic [`GP0_PINS-1:0] ext_irq_in
);

	gp0_state_type s_q;
	gp0_state_type s_d;

	// Register index and hit flag for a byte address
	function automatic logic [2:0] gp0_decode(input logic [`GP0_ADDR_W-1:0] addr);
		logic [2:0] r;
		r = 3'h0;
		case (addr)
			`GP0_OFS_DATA: begin
				r = {1'b1, `GP0_IDX_DATA};
			end
			`GP0_OFS_DIR: begin
				r = {1'b1, `GP0_IDX_DIR};
			end
			`GP0_OFS_PULL: begin
				r = {1'b1, `GP0_IDX_PULL};
			end
			`GP0_OFS_RMW: begin
				r = {1'b1, `GP0_IDX_RMW};
			end
			default: begin
				r = 3'h0;
			end
		endcase
		return r;
	endfunction

	// Handshake inputs of each channel
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic aw_ok;
	logic w_ok;
	logic [`GP0_ADDR_W-1:0] wr_addr;
	logic [`GP0_DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic [2:0] wr_sel;
	logic [2:0] rd_sel;

	// Address and data are held off while a response waits
	assign s_axi_awready = ~s_q.aw_have & (s_q.wr_st == GP0_WR_IDLE);
	assign s_axi_wready = ~s_q.w_have & (s_q.wr_st == GP0_WR_IDLE);
	// One read in flight; the next is taken after rvalid clears
	assign s_axi_arready = ~s_q.rvalid;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign aw_ok = s_q.aw_have | aw_take;
	assign w_ok = s_q.w_have | w_take;

	// Either channel may arrive first; the held copy fills the gap
	assign wr_addr = s_q.aw_have ? s_q.aw_addr : s_axi_awaddr;
	assign wr_data = s_q.w_have ? s_q.w_data : s_axi_wdata;
	assign wr_strb = s_q.w_have ? s_q.w_strb : s_axi_wstrb;
	assign wr_sel = gp0_decode(wr_addr);
	assign rd_sel = gp0_decode(s_axi_araddr);

	// Next state of bus slave and port registers
	always_comb begin
		s_d = s_q;

		// Write path
		case (s_q.wr_st)
			GP0_WR_IDLE: begin
				if (aw_take) begin
					s_d.aw_have = 1'b1;
					s_d.aw_addr = s_axi_awaddr;
				end
				if (w_take) begin
					s_d.w_have = 1'b1;
					s_d.w_data = s_axi_wdata;
					s_d.w_strb = s_axi_wstrb;
				end
				if (aw_ok && w_ok) begin
					s_d.aw_have = 1'b0;
					s_d.w_have = 1'b0;
					s_d.wr_st = GP0_WR_RESP;
					s_d.bresp = wr_sel[2] ? `GP0_RESP_OKAY : `GP0_RESP_SLVERR;
					// Only the low byte lane carries register bits
					if (wr_sel[2] && wr_strb[0]) begin
						case (wr_sel[1:0])
							`GP0_IDX_DATA, `GP0_IDX_RMW: begin
								s_d.latch = wr_data[`GP0_PINS-1:0];
							end
							`GP0_IDX_DIR: begin
								s_d.dir = wr_data[`GP0_PINS-1:0];
							end
							`GP0_IDX_PULL: begin
								s_d.pull = wr_data[`GP0_PINS-1:0];
							end
							default: begin
								s_d.latch = s_q.latch;
							end
						endcase
					end
				end
			end
			GP0_WR_RESP: begin
				if (s_axi_bready) begin
					s_d.wr_st = GP0_WR_IDLE;
				end
			end
			default: begin
				s_d.wr_st = GP0_WR_IDLE;
			end
		endcase

		// Read path
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = rd_sel[2] ? `GP0_RESP_OKAY : `GP0_RESP_SLVERR;
			s_d.rdata = '0;
			if (rd_sel[2]) begin
				case (rd_sel[1:0])
					`GP0_IDX_DATA: begin
						s_d.rdata[`GP0_PINS-1:0] = pin_in;
					end
					`GP0_IDX_RMW: begin
						// Latch view serves read-modify-write sequences
						s_d.rdata[`GP0_PINS-1:0] = s_q.latch;
					end
					`GP0_IDX_DIR: begin
						s_d.rdata[`GP0_PINS-1:0] = s_q.dir;
					end
					`GP0_IDX_PULL: begin
						s_d.rdata[`GP0_PINS-1:0] = s_q.pull;
					end
					default: begin
						s_d.rdata = '0;
					end
				endcase
			end
		end

		// Every pin level goes on to its interrupt input
		s_d.irq = pin_in;
	end

	// Registered state; direction clears so no pin drives after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.wr_st <= GP0_WR_IDLE;
			s_q.bresp <= `GP0_RESP_OKAY;
			s_q.rresp <= `GP0_RESP_OKAY;
			s_q.latch <= `GP0_RST_LATCH;
			s_q.dir <= `GP0_RST_DIR;
			s_q.pull <= `GP0_RST_PULL;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_bvalid = (s_q.wr_st == GP0_WR_RESP);
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign ext_irq_in = s_q.irq;

	// One output stage per pin, bit n to pin n
	for (genvar n = 0; n < `GP0_PINS; n++) begin : g_pin
		gp0_pin_cell u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.latch_bit(s_q.latch[n]),
			.dir_bit(s_q.dir[n]),
			.pull_bit(s_q.pull[n]),
			.pin_out(pins.pin_out[n]),
			.pin_oe_n(pins.pin_oe_n[n]),
			.pull_up_en(pins.pull_up_en[n])
		);
	end

endmodule

/* File: tb_gp0_port.sv */
// Self-checking bench for the eight-pin port
`timescale 1ns/100ps
module tb_gp0_port
	import gp0_pkg::*;
;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	// Response codes taken at the answering edge
	logic [1:0] b_seen = 2'h0, r_seen = 2'h0;
	logic [7:0] pin_in, ext_irq_in, ext_en = 8'h00, ext_lvl = 8'h00;
	gp0_pins_out_type pins;
	int n_mismatch = 0, checks_done = 0, cyc = 0;

	gp0_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pins(pins), .ext_irq_in(ext_irq_in));
	gp0_board u_board (.aclk(aclk), .pins(pins), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

	// 10 MHz clock
	initial begin
		forever #50 aclk = ~aclk;
	end
	// Watchdog, far above the fewer than a hundred cycles needed
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		b_seen = bresp;
		bready <= 1'h0;
	endtask

	// Read and compare the returned word
	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		r_seen = rresp;
		rready <= 1'h0;
		chk(nm, rdata, exp);
	endtask

	// Reset state: all pins inputs
	task automatic t_reset();
		@(negedge aclk);
		chk("oe_n", 32'(pins.pin_oe_n), 32'hff);
		rchk("dir", 5'h04, 32'h0);
	endtask

	// Plain registers read back, unmapped write changes nothing
	task automatic t_regs();
		logic [4:0] a;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			a = i[0] ? 5'h08 : 5'h04;
			v = i[1] ? 8'ha5 : 8'h5a;
			wr(a, v);
			chk("bresp", 32'(b_seen), 32'h0);
			rchk("rw", a, {24'h0, v});
			chk("rresp", 32'(r_seen), 32'h0);
		end
		wr(5'h10, 8'hff);
		chk("bresp_err", 32'(b_seen), 32'h2);
		rchk("dir", 5'h04, 32'ha5);
		rchk("unmapped", 5'h10, 32'h0);
		chk("rresp_err", 32'(r_seen), 32'h2);
	endtask

	// Drive, live read, latch view, pull-ups, interrupt feed
	task automatic t_pins();
		wr(5'h04, 8'h0f);
		wr(5'h08, 8'hf0);
		wr(5'h00, 8'h35);
		ext_en <= 8'hf0;
		ext_lvl <= 8'h90;
		repeat (2) @(posedge aclk);
		// Outputs looked at mid-cycle, well clear of the launching edge
		@(negedge aclk);
		chk("oe_n", 32'(pins.pin_oe_n), 32'hf0);
		chk("drive", 32'(pins.pin_out & 8'h0f), 32'h05);
		chk("pull", 32'(pins.pull_up_en), 32'hf0);
		chk("irq", 32'(ext_irq_in), 32'h95);
		rchk("live", 5'h00, 32'h95);
		rchk("latch", 5'h0c, 32'h35);
		ext_en <= 8'h00;
		rchk("pulled", 5'h00, 32'hf5);
		// Latch loaded through the latch view, then pull-ups on driven-low pins
		wr(5'h0c, 8'hca);
		wr(5'h08, 8'hff);
		@(negedge aclk);
		chk("drive_rmw", 32'(pins.pin_out & 8'h0f), 32'h0a);
		chk("pull_drop", 32'(pins.pull_up_en), 32'hfa);
		rchk("latch_rmw", 5'h0c, 32'hca);
		rchk("live_rmw", 5'h00, 32'hfa);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Reset for 8 cycles, then the scenarios
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_regs();
		t_pins();
		wrap_up();
	end
endmodule
